// File: ata_cmd_engine.sv
// task-file command engine: diagnostic, cache flush, format track, identify
`timescale 1ns/1ps
`default_nettype none
`include "ata_cmd_params.svh"
module ata_cmd_engine (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  output logic host_irq_o,
  input wire logic slave_diag_fail_i,
  input wire logic [3:0] test_fault_i,
  output logic flush_req_o,
  input wire logic flush_done_i,
  output logic fmt_req_o,
  output logic fmt_lba_o,
  output logic [27:0] fmt_start_o,
  output logic [8:0] fmt_count_o,
  output logic [7:0] fmt_fill_o,
  input wire logic fmt_done_i
);
  import ata_cmd_pkg::*;

  engine_state_type r;
  engine_state_type n;
  logic wr;
  logic rd;
  logic sel_ok;
  logic cmd_wr;
  logic is_diag;
  logic go;
  logic abort;
  logic finish;
  logic [2:0] irq_set;
  logic [2:0] isr_clr;
  logic [7:0] stat;

  diag_link_if dl ();

  self_test_unit u_self_test (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .lnk(dl.eng)
  );

  assign dl.start = r.diag_start;
  assign dl.fault = r.s2[3:0];

  // ----------------------------------------
  // parameter block contents
  // ----------------------------------------
  // words not listed are reserved and read as zero
  function automatic logic [15:0] ident_word(input logic [7:0] idx, input logic ide);
    case (idx)
      `IDW_IX_GEN: ident_word = ide ? `IDW_GEN_IDE : `IDW_GEN_PCC;
      `IDW_IX_CYLS: ident_word = `IDW_CYLS;
      `IDW_IX_HEADS: ident_word = `IDW_HEADS;
      `IDW_IX_SPT: ident_word = `IDW_SPT;
      `IDW_IX_CAP_HI: ident_word = `IDW_CAP_HI;
      `IDW_IX_CAP_LO: ident_word = `IDW_CAP_LO;
      default: ident_word = 16'h0000; // see RL15
    endcase
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    n = r;
    wr = wb_cyc_i & wb_stb_i & wb_we_i & r.ack;
    rd = wb_cyc_i & wb_stb_i & ~wb_we_i & r.ack;
    sel_ok = (r.dh[`DH_DRV] == r.cfg[`CFG_DEVID]);
    cmd_wr = wr & wb_sel_i[0] & ~r.bsy & ~r.drq & (wb_adr_i == `ADR_CMD);
    is_diag = (wb_dat_i[7:0] == `CMD_DIAG);
    go = cmd_wr & (sel_ok | (is_diag & r.cfg[`CFG_IDE])); // see RL2 RL3
    abort = 1'b0;
    finish = 1'b0;
    irq_set = 3'b000;
    isr_clr = 3'b000;
    stat = 8'h00;
    stat[`ST_BSY] = r.bsy;
    stat[`ST_RDY] = r.rdy;
    stat[`ST_DSC] = r.seek_complete_flag;
    stat[`ST_DRQ] = r.drq;
    stat[`ST_ERR] = r.errb;
    // pins from the media side pass two flops
    n.s1 = {fmt_done_i, flush_done_i, slave_diag_fail_i, test_fault_i};
    n.s2 = r.s1;
    n.ack = wb_cyc_i & wb_stb_i & ~r.ack;
    n.diag_start = 1'b0;

    // read data is prepared in the request cycle and held over the ack cycle
    if (wb_cyc_i & wb_stb_i & ~r.ack) begin
      case (wb_adr_i)
        `ADR_CMD: n.rdat = {24'h000000, r.cmd};
        `ADR_DH: n.rdat = {24'h000000, r.dh};
        `ADR_CYL: n.rdat = {16'h0000, r.cyl_hi, r.cyl_lo};
        `ADR_SEC: n.rdat = {16'h0000, r.snum, r.scnt};
        `ADR_STATUS: n.rdat = {16'h0000, r.err, stat};
        `ADR_DATA: begin
          if (r.st == ST_IDENT) begin
            n.rdat = {16'h0000, ident_word(r.widx, r.cfg[`CFG_IDE])};
          end else begin
            n.rdat = 32'h00000000;
          end
        end
        `ADR_CFG: n.rdat = {27'h0000000, r.cfg};
        `ADR_ISR: n.rdat = {29'h00000000, r.isr};
        `ADR_IMASK: n.rdat = {29'h00000000, r.imask};
        default: n.rdat = 32'h00000000;
      endcase
    end

    // reading status acknowledges the host interrupt
    if (rd & (wb_adr_i == `ADR_STATUS)) begin
      n.hirq = 1'b0;
    end

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    if (wr) begin
      case (wb_adr_i)
        `ADR_DH: begin
          if (wb_sel_i[0] & ~r.bsy) begin
            n.dh = wb_dat_i[7:0];
          end
        end
        `ADR_CYL: begin
          if (wb_sel_i[0] & ~r.bsy) begin
            n.cyl_lo = wb_dat_i[7:0];
          end
          if (wb_sel_i[1] & ~r.bsy) begin
            n.cyl_hi = wb_dat_i[15:8];
          end
        end
        `ADR_SEC: begin
          if (wb_sel_i[0] & ~r.bsy) begin
            n.scnt = wb_dat_i[7:0];
          end
          if (wb_sel_i[1] & ~r.bsy) begin
            n.snum = wb_dat_i[15:8];
          end
        end
        `ADR_CFG: begin
          if (wb_sel_i[0]) begin
            n.cfg = wb_dat_i[4:0];
          end
        end
        `ADR_ISR: begin
          if (wb_sel_i[0]) begin
            isr_clr = wb_dat_i[2:0];
          end
        end
        `ADR_IMASK: begin
          if (wb_sel_i[0]) begin
            n.imask = wb_dat_i[2:0];
          end
        end
        default: begin
        end
      endcase
    end

    // ----------------------------------------
    // command issue
    // ----------------------------------------
    if (go) begin
      n.cmd = wb_dat_i[7:0];
      n.hirq = 1'b0;
      n.errb = 1'b0;
      n.err = 8'h00;
      // only the drive bit has been looked at; only format later uses the other task-file regs
      case (wb_dat_i[7:0]) // see RL16
        `CMD_DIAG: begin
          n.st = ST_DIAG;
          n.bsy = 1'b1;
          n.diag_start = 1'b1; // see RL1
        end
        `CMD_FLUSH: begin
          if (r.cfg[`CFG_FLUSH_EN]) begin
            n.st = ST_FLUSH;
            n.bsy = 1'b1;
            n.seek_complete_flag = 1'b0;
            n.flush_req = 1'b1; // see RL6
          end else begin
            abort = 1'b1; // see RL8
          end
        end
        `CMD_FORMAT: begin
          n.st = ST_FMT_DATA;
          n.drq = 1'b1; // see RL10
          n.widx = 8'h00;
          irq_set[`IRQ_DRQ] = 1'b1;
        end
        `CMD_IDENT: begin
          n.st = ST_IDENT;
          n.drq = 1'b1; // see RL14
          n.widx = 8'h00;
          n.hirq = ~r.cfg[`CFG_NIEN];
          irq_set[`IRQ_DRQ] = 1'b1;
        end
        default: abort = 1'b1;
      endcase
    end

    // ----------------------------------------
    // command execution
    // ----------------------------------------
    case (r.st)
      ST_IDLE: begin
      end
      ST_DIAG: begin
        if (dl.done) begin
          if (r.cfg[`CFG_IDE] & ~r.cfg[`CFG_DEVID] & r.s2[4]) begin
            n.err = {`DIAG_SLAVE_NIB, dl.code[3:0]}; // see RL5 RL3
          end else begin
            n.err = dl.code; // see RL4
          end
          finish = 1'b1;
        end
      end
      ST_FLUSH: begin
        if (r.s2[5]) begin
          n.flush_req = 1'b0;
          finish = 1'b1; // see RL7
        end
      end
      ST_FMT_DATA: begin
        // host words are counted and thrown away
        if (wr & (wb_adr_i == `ADR_DATA)) begin
          n.widx = r.widx + 8'h01; // see RL10
          if (r.widx == `BLK_LAST) begin
            n.st = ST_FMT_MEDIA;
            n.drq = 1'b0;
            n.bsy = 1'b1;
            n.fmt_req = 1'b1; // see RL9
            n.fmt_lba = r.dh[`DH_LBA];
            n.fmt_start = {r.dh[3:0], r.cyl_hi, r.cyl_lo, 8'h00}; // see RL12
            if (r.dh[`DH_LBA]) begin
              n.fmt_cnt = (r.scnt == 8'h00) ? `SC_ZERO_CNT : {1'b0, r.scnt}; // see RL11
            end else begin
              n.fmt_cnt = 9'h000;
            end
            n.fmt_fill = r.cfg[`CFG_FILL] ? `FILL_ONES : `FILL_ZEROS;
          end
        end
      end
      ST_FMT_MEDIA: begin
        if (r.s2[6]) begin
          n.fmt_req = 1'b0;
          finish = 1'b1;
        end
      end
      ST_IDENT: begin
        if (rd & (wb_adr_i == `ADR_DATA)) begin
          n.widx = r.widx + 8'h01;
          if (r.widx == `BLK_LAST) begin
            finish = 1'b1; // see RL14
          end
        end
      end
      default: n.st = ST_IDLE;
    endcase

    if (abort) begin
      n.err = `ERR_ABRT;
      n.errb = 1'b1;
      irq_set[`IRQ_ERR] = 1'b1;
      finish = 1'b1;
    end

    if (finish) begin
      n.st = ST_IDLE;
      n.bsy = 1'b0; // see RL17
      n.drq = 1'b0;
      n.rdy = 1'b1;
      n.seek_complete_flag = 1'b1;
      n.hirq = ~r.cfg[`CFG_NIEN]; // see RL17
      irq_set[`IRQ_DONE] = 1'b1;
    end

    // a new event wins over a clear in the same cycle
    n.isr = (r.isr & ~isr_clr) | irq_set;
    n.irq = |(n.isr & n.imask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.st <= ST_IDLE;
      r.rdy <= 1'b1;
      r.seek_complete_flag <= 1'b1;
      r.cfg <= `CFG_RESET;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign wb_dat_o = r.rdat;
  assign wb_ack_o = r.ack;
  assign irq_o = r.irq;
  assign host_irq_o = r.hirq;
  assign flush_req_o = r.flush_req;
  assign fmt_req_o = r.fmt_req;
  assign fmt_lba_o = r.fmt_lba;
  assign fmt_start_o = r.fmt_start;
  assign fmt_count_o = r.fmt_cnt;
  assign fmt_fill_o = r.fmt_fill;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_DIAG_START: assert property (go && is_diag |=> r.st == ST_DIAG && r.bsy) // see RL1
    else $error("diagnostic not started");
  AST_PC_UNSEL: assert property (cmd_wr && !sel_ok && !r.cfg[`CFG_IDE] // see RL2
    |=> r.st == ST_IDLE)
    else $error("unselected card ran a command");
  AST_IDE_BOTH: assert property (cmd_wr && is_diag && r.cfg[`CFG_IDE] // see RL3
    |=> r.st == ST_DIAG)
    else $error("diagnostic skipped in true ide mode");
  AST_DIAG_CODE: assert property (r.st == ST_DIAG && dl.done && !r.s2[4] |=> // see RL4
    r.err == $past(dl.code) && !r.bsy)
    else $error("diagnostic code not loaded");
  AST_SLAVE_FLAG: assert property (r.st == ST_DIAG && dl.done && r.s2[4] // see RL5
    && r.cfg[`CFG_IDE] && !r.cfg[`CFG_DEVID] |=> r.err[7:4] == `DIAG_SLAVE_NIB)
    else $error("slave failure not flagged");
  AST_FLUSH_REQ: assert property (go && wb_dat_i[7:0] == `CMD_FLUSH // see RL6
    && r.cfg[`CFG_FLUSH_EN] |=> r.flush_req && r.bsy)
    else $error("flush not requested");
  AST_FLUSH_DONE: assert property ($fell(r.bsy) && $past(r.st) == ST_FLUSH |-> // see RL7
    r.rdy && r.seek_complete_flag && !r.flush_req)
    else $error("flush finished without ready and seek complete");
  AST_FLUSH_ABORT: assert property (go && wb_dat_i[7:0] == `CMD_FLUSH // see RL8
    && !r.cfg[`CFG_FLUSH_EN] |=> r.err == `ERR_ABRT && r.errb && !r.bsy)
    else $error("unsupported flush not aborted");
  AST_FMT_ADDR: assert property ($rose(r.fmt_req) |-> // see RL12
    r.fmt_start == {r.dh[3:0], r.cyl_hi, r.cyl_lo, 8'h00})
    else $error("format start address wrong");
  AST_FMT_CNT: assert property ($rose(r.fmt_req) && r.fmt_lba && r.scnt == 8'h00 |-> // see RL11
    r.fmt_cnt == `SC_ZERO_CNT)
    else $error("format count zero not taken as 256");
  AST_FMT_DATA: assert property (r.st == ST_FMT_DATA |-> r.drq && !r.fmt_req) // see RL10
    else $error("format buffer phase wrong");
  AST_IDENT_RSVD: assert property (rd && r.st == ST_IDENT && r.widx == `IDW_IX_RSVD // see RL15
    && wb_adr_i == `ADR_DATA |-> r.rdat == 32'h00000000)
    else $error("reserved identify word not zero");
  AST_HOST_IRQ: assert property ($fell(r.bsy) && !r.cfg[`CFG_NIEN] |-> r.hirq) // see RL17
    else $error("host interrupt missing at completion");

  COV_DIAG: cover property (r.st == ST_DIAG ##1 r.st == ST_IDLE);
  COV_FLUSH: cover property (r.st == ST_FLUSH ##1 r.st == ST_IDLE);
  COV_FORMAT: cover property (r.st == ST_FMT_MEDIA ##1 r.st == ST_IDLE);
  COV_IDENT: cover property (r.st == ST_IDENT ##1 r.st == ST_IDLE);
endmodule
`default_nettype wire

// File: ata_cmd_params.svh
// constants of the task-file command engine: offsets, fields, codes, reset values
// Function
// RL1 - command 90h runs self-tests of formatter, sector buffer, ECC and processor
// RL2 - PC-card configuration: only the drive picked by drive-select runs diagnostic
// RL3 - True IDE: both drives run diagnostic; master reports combined status
// RL4 - diagnostic result code in error register: 01h ok, 02h-05h unit fault
// RL5 - True IDE master flags a failing slave with upper nibble 8
// RL6 - command E7h writes all cached data to the flash media
// RL7 - flush completes only after media write, with ready and seek-complete set
// RL8 - a card without cache flush aborts that command
// RL9 - command 50h fills addressed head and cylinder with a fixed pattern
// RL10 - format takes one host sector buffer by write handshake, then discards it
// RL11 - format in LBA mode takes sector count, zero meaning 256
// RL12 - format start from head bits and cylinders; sector number ignored
// RL13 - host should not issue format at all; kept for compatibility only
// RL14 - command ECh returns one parameter block like a single sector read
// RL15 - reserved bits and words of the parameter block read as zero
// RL16 - diagnostic, flush, identify use only the drive-select bit
// RL17 - each command ends with busy cleared and host interrupt unless disabled
`ifndef ATA_CMD_PARAMS_SVH
`define ATA_CMD_PARAMS_SVH
// ----------------------------------------
// command codes
// ----------------------------------------
`define CMD_DIAG 8'h90
`define CMD_FLUSH 8'hE7
`define CMD_FORMAT 8'h50
`define CMD_IDENT 8'hEC
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ADR_CMD 8'h00
`define ADR_DH 8'h04
`define ADR_CYL 8'h08
`define ADR_SEC 8'h0C
`define ADR_STATUS 8'h10
`define ADR_DATA 8'h14
`define ADR_CFG 8'h18
`define ADR_ISR 8'h1C
`define ADR_IMASK 8'h20
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define ST_BSY 7
`define ST_RDY 6
`define ST_DSC 4
`define ST_DRQ 3
`define ST_ERR 0
`define DH_LBA 6
`define DH_DRV 4
`define CFG_IDE 0
`define CFG_DEVID 1
`define CFG_FLUSH_EN 2
`define CFG_NIEN 3
`define CFG_FILL 4
`define CFG_RESET 5'h04
`define IRQ_DONE 0
`define IRQ_DRQ 1
`define IRQ_ERR 2
`define ERR_ABRT 8'h04
`define DIAG_OK 8'h01
`define DIAG_FORMATTER 8'h02
`define DIAG_SLAVE_NIB 4'h8
`define DIAG_LAST_STEP 2'h3
`define FILL_ONES 8'hFF
`define FILL_ZEROS 8'h00
`define BLK_LAST 8'hFF
`define SC_ZERO_CNT 9'h100
// ----------------------------------------
// parameter block words
// ----------------------------------------
`define IDW_IX_GEN 8'h00
`define IDW_IX_CYLS 8'h01
`define IDW_IX_RSVD 8'h02
`define IDW_IX_HEADS 8'h03
`define IDW_IX_SPT 8'h06
`define IDW_IX_CAP_HI 8'h07
`define IDW_IX_CAP_LO 8'h08
`define IDW_GEN_PCC 16'h848A
`define IDW_GEN_IDE 16'h045A
`define IDW_CYLS 16'h0100
`define IDW_HEADS 16'h0010
`define IDW_SPT 16'h0020
`define IDW_CAP_HI 16'h0002
`define IDW_CAP_LO 16'h0000
`endif

// File: ata_cmd_pkg.sv
// types of the task-file command engine and its self-test unit
package ata_cmd_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_DIAG = 6'h02,
    ST_FLUSH = 6'h04,
    ST_FMT_DATA = 6'h08,
    ST_FMT_MEDIA = 6'h10,
    ST_IDENT = 6'h20
  } cmd_state_type;

  typedef struct packed {
    cmd_state_type st;
    logic [7:0] cmd;
    logic [7:0] dh;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic [7:0] scnt;
    logic [7:0] snum;
    logic [7:0] err;
    logic bsy;
    logic rdy;
    logic seek_complete_flag;
    logic drq;
    logic errb;
    logic [4:0] cfg;
    logic [2:0] isr;
    logic [2:0] imask;
    logic irq;
    logic [7:0] widx;
    logic ack;
    logic [31:0] rdat;
    logic hirq;
    logic flush_req;
    logic fmt_req;
    logic fmt_lba;
    logic [27:0] fmt_start;
    logic [8:0] fmt_cnt;
    logic [7:0] fmt_fill;
    logic [6:0] s1;
    logic [6:0] s2;
    logic diag_start;
  } engine_state_type;

  typedef struct packed {
    logic busy;
    logic [1:0] step;
    logic [7:0] code;
    logic done;
  } diag_state_type;
endpackage

// File: ata_diag_flush_format_identify_test.sv
// self-checking bench of the task-file command engine
`timescale 1ns/1ps
`default_nettype none
`include "ata_cmd_params.svh"
module ata_diag_flush_format_identify_test;
  import ata_cmd_pkg::*;
  typedef struct packed {
    logic [7:0] cfg; logic [7:0] dh; logic [3:0] fault; logic sfail;
    logic [7:0] cmd; logic [7:0] err; logic errb; logic hirq;
  } row_type;
  row_type rows [0:12] = '{
    '{8'h04, 8'h2F, 4'h0, 1'b0, `CMD_DIAG, `DIAG_OK, 1'b0, 1'b1},
    '{8'h04, 8'h2F, 4'h1, 1'b0, `CMD_DIAG, `DIAG_FORMATTER, 1'b0, 1'b1},
    '{8'h04, 8'h00, 4'h2, 1'b0, `CMD_DIAG, 8'h03, 1'b0, 1'b1},
    '{8'h04, 8'h00, 4'h4, 1'b0, `CMD_DIAG, 8'h04, 1'b0, 1'b1},
    '{8'h04, 8'h00, 4'h8, 1'b0, `CMD_DIAG, 8'h05, 1'b0, 1'b1},
    '{8'h04, 8'h00, 4'h6, 1'b0, `CMD_DIAG, 8'h03, 1'b0, 1'b1},
    '{8'h05, 8'h10, 4'h0, 1'b1, `CMD_DIAG, 8'h81, 1'b0, 1'b1},
    '{8'h05, 8'h10, 4'h4, 1'b0, `CMD_DIAG, 8'h04, 1'b0, 1'b1},
    '{8'h05, 8'h00, 4'h2, 1'b1, `CMD_DIAG, 8'h83, 1'b0, 1'b1},
    '{8'h0C, 8'h00, 4'h0, 1'b0, `CMD_DIAG, `DIAG_OK, 1'b0, 1'b0},
    '{8'h00, 8'h00, 4'h0, 1'b0, `CMD_FLUSH, `ERR_ABRT, 1'b1, 1'b1},
    '{8'h07, 8'h10, 4'h0, 1'b1, `CMD_DIAG, `DIAG_OK, 1'b0, 1'b1},
    '{8'h04, 8'h00, 4'h0, 1'b0, 8'hA5, `ERR_ABRT, 1'b1, 1'b1}};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq, host_irq;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] dat_w = 32'h0, dat_r, rv;
  logic slave_fail = 1'b0, flush_req, flush_done, fmt_req, fmt_lba, fmt_done;
  logic [3:0] test_fault = 4'h0;
  logic [27:0] fmt_start;
  logic [8:0] fmt_count;
  logic [7:0] fmt_fill;
  logic [7:0] delay = 8'h1E;
  int bad_count = 0;
  int n_tests = 0;
  int i, w, n;
  row_type r;

  ata_cmd_engine DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .irq_o(irq), .host_irq_o(host_irq), .slave_diag_fail_i(slave_fail),
    .test_fault_i(test_fault), .flush_req_o(flush_req), .flush_done_i(flush_done),
    .fmt_req_o(fmt_req), .fmt_lba_o(fmt_lba), .fmt_start_o(fmt_start),
    .fmt_count_o(fmt_count), .fmt_fill_o(fmt_fill), .fmt_done_i(fmt_done));
  media_model PARTNER (.clk_i(clk_i), .rst_i(rst_i), .delay_i(delay),
    .flush_req_i(flush_req), .fmt_req_i(fmt_req), .flush_done_o(flush_done),
    .fmt_done_o(fmt_done));

  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // compare, bus and wait helpers
  // ----------------------------------------
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %b", $time, what, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= wr; adr <= a; dat_w <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 64);
    rv = dat_r;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (k >= 64) chk_bit(1'b0, 1'b1, "no bus ack");
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic wait_irq(input string what);
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 400) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 400) chk_bit(1'b0, 1'b1, what);
  endtask
  function automatic logic [15:0] id_word(input logic [7:0] ix, input logic ide);
    case (ix)
      `IDW_IX_GEN: id_word = ide ? `IDW_GEN_IDE : `IDW_GEN_PCC;
      `IDW_IX_CYLS: id_word = `IDW_CYLS;
      `IDW_IX_HEADS: id_word = `IDW_HEADS;
      `IDW_IX_SPT: id_word = `IDW_SPT;
      `IDW_IX_CAP_HI: id_word = `IDW_CAP_HI;
      `IDW_IX_CAP_LO: id_word = `IDW_CAP_LO;
      default: id_word = 16'h0000;
    endcase
  endfunction
  task automatic fmt_run(input logic [7:0] cfg, input logic [7:0] dh, input logic [7:0] sc,
                         input logic [8:0] cnt, input logic [7:0] fill);
    int k;
    wr(`ADR_CFG, {24'h0, cfg});
    wr(`ADR_DH, {24'h0, dh});
    wr(`ADR_CYL, 32'h1234);
    wr(`ADR_SEC, {16'h0, 8'h99, sc});
    wr(`ADR_IMASK, 32'h2);
    wr(`ADR_CMD, {24'h0, `CMD_FORMAT});
    wait_irq("no format data request");
    wr(`ADR_IMASK, 32'h1);
    wr(`ADR_ISR, 32'h7);
    for (k = 0; k < 256; k++) wr(`ADR_DATA, k);
    k = 0;
    while (fmt_req !== 1'b1 && k < 100) begin
      @(posedge clk_i);
      k++;
    end
    chk_bit(fmt_req, 1'b1, "format request");
    chk_word({4'h0, fmt_start}, {4'h0, dh[3:0], 24'h123400}, "format start");
    chk_word({23'h0, fmt_count}, {23'h0, cnt}, "format count");
    chk_word({24'h0, fmt_fill}, {24'h0, fill}, "format fill");
    chk_bit(fmt_lba, dh[`DH_LBA], "format lba");
    wait_irq("no format done");
    rd(`ADR_STATUS);
    chk_word(rv & 32'h89, 32'h0, "format end status");
    wr(`ADR_ISR, 32'h7);
  endtask
  task automatic conclude();
    if (bad_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`ADR_STATUS);
    chk_word(rv, 32'h50, "status after reset");
    rd(`ADR_CFG);
    chk_word(rv, 32'h4, "config after reset");
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h40);
    chk_word(rv, 32'h0, "unmapped read");
    for (i = 0; i < 13; i++) begin
      r = rows[i];
      wr(`ADR_CFG, {24'h0, r.cfg});
      wr(`ADR_IMASK, 32'h1);
      wr(`ADR_DH, {24'h0, r.dh});
      @(posedge clk_i);
      test_fault <= r.fault;
      slave_fail <= r.sfail;
      repeat (3) @(posedge clk_i);
      wr(`ADR_CMD, {24'h0, r.cmd});
      wait_irq("no command done");
      chk_bit(host_irq, r.hirq, "host interrupt");
      rd(`ADR_ISR);
      chk_word(rv, {29'h0, r.errb, 2'b01}, "event bits");
      rd(`ADR_STATUS);
      chk_word(rv & 32'hFF81, {16'h0, r.err, 7'h0, r.errb}, "result code");
      repeat (2) @(posedge clk_i);
      chk_bit(host_irq, 1'b0, "host interrupt after status");
      wr(`ADR_ISR, 32'h7);
      repeat (2) @(posedge clk_i);
      chk_bit(irq, 1'b0, "interrupt after clear");
    end
    test_fault <= 4'h0;
    slave_fail <= 1'b0;
    wr(`ADR_CFG, 32'h4);
    wr(`ADR_DH, 32'h10);
    wr(`ADR_CMD, {24'h0, `CMD_DIAG});
    repeat (20) @(posedge clk_i);
    rd(`ADR_ISR);
    chk_word(rv, 32'h0, "unselected drive ran");
    wr(`ADR_DH, 32'h0);
    wr(`ADR_CMD, {24'h0, `CMD_FLUSH});
    n = 0;
    while (flush_req !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    chk_bit(flush_req, 1'b1, "flush request");
    rd(`ADR_STATUS);
    chk_word(rv & 32'h90, 32'h80, "flush pending status");
    wait_irq("no flush done");
    chk_bit(flush_req, 1'b0, "flush request after done");
    rd(`ADR_STATUS);
    chk_word(rv & 32'hD9, 32'h50, "flush end status");
    wr(`ADR_ISR, 32'h7);
    for (i = 0; i < 2; i++) begin
      wr(`ADR_CFG, {31'h2, i[0]});
      wr(`ADR_IMASK, 32'h2);
      wr(`ADR_CMD, {24'h0, `CMD_IDENT});
      wait_irq("no identify data request");
      chk_bit(host_irq, 1'b1, "identify host interrupt");
      wr(`ADR_IMASK, 32'h1);
      wr(`ADR_ISR, 32'h7);
      for (w = 0; w < 256; w++) begin
        rd(`ADR_DATA);
        chk_word(rv, {16'h0, id_word(w[7:0], i[0])}, "identify word");
      end
      wait_irq("no identify done");
      wr(`ADR_ISR, 32'h7);
    end
    fmt_run(8'h14, 8'h4A, 8'h00, `SC_ZERO_CNT, `FILL_ONES);
    fmt_run(8'h04, 8'h05, 8'h07, 9'h000, `FILL_ZEROS);
    // reset in the middle of a pending flush
    wr(`ADR_CMD, {24'h0, `CMD_FLUSH});
    repeat (4) @(posedge clk_i);
    chk_bit(flush_req, 1'b1, "flush request before reset");
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    chk_bit(flush_req, 1'b0, "flush request in reset");
    rd(`ADR_STATUS);
    chk_word(rv, 32'h50, "status after mid-run reset");
    conclude();
  end
  initial begin
    #400000;
    bad_count++;
    conclude();
  end
endmodule
`default_nettype wire

// File: diag_link_if.sv
// link between the command engine and the self-test unit
`timescale 1ns/1ps
`default_nettype none
interface diag_link_if;
  logic start;
  logic [3:0] fault;
  logic done;
  logic [7:0] code;
  modport eng (input start, input fault, output done, output code);
  modport ctl (output start, output fault, input done, input code);
endinterface
`default_nettype wire

// File: media_model.sv
// flash media side: answers flush and format requests after a set delay
`timescale 1ns/1ps
`default_nettype none
module media_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] delay_i,
  input wire logic flush_req_i,
  input wire logic fmt_req_i,
  output logic flush_done_o,
  output logic fmt_done_o
);
  logic [7:0] cnt_r;
  // ----------------------------------------
  // four-phase completion: done holds until the request drops
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 8'h00;
      flush_done_o <= 1'b0;
      fmt_done_o <= 1'b0;
    end else if ((flush_req_i && !flush_done_o) || (fmt_req_i && !fmt_done_o)) begin
      if (cnt_r >= delay_i) begin
        cnt_r <= 8'h00;
        flush_done_o <= flush_req_i;
        fmt_done_o <= fmt_req_i;
      end else begin
        cnt_r <= cnt_r + 8'h01;
      end
    end else begin
      cnt_r <= 8'h00;
      if (!flush_req_i) flush_done_o <= 1'b0;
      if (!fmt_req_i) fmt_done_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: self_test_unit.sv
// self-test sequencer: checks formatter, buffer, ECC and processor in turn
`timescale 1ns/1ps
`default_nettype none
`include "ata_cmd_params.svh"
module self_test_unit (
  input wire logic clk_i,
  input wire logic rst_i,
  diag_link_if.eng lnk
);
  import ata_cmd_pkg::*;

  diag_state_type r;
  diag_state_type n;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    n = r;
    n.done = 1'b0;
    if (lnk.start & ~r.busy) begin
      n.busy = 1'b1;
      n.step = 2'h0;
    end else if (r.busy) begin
      // first failing unit gives the code: formatter 02h up to processor 05h
      if (lnk.fault[r.step]) begin
        n.code = `DIAG_FORMATTER + {6'h00, r.step}; // see RL4
        n.busy = 1'b0;
        n.done = 1'b1;
      end else if (r.step == `DIAG_LAST_STEP) begin
        n.code = `DIAG_OK; // see RL1
        n.busy = 1'b0;
        n.done = 1'b1;
      end else begin
        n.step = r.step + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign lnk.done = r.done;
  assign lnk.code = r.code;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_ST_RUNS: assert property (lnk.start && !r.busy |-> ##[2:5] lnk.done) // see RL1
    else $error("self-test did not finish in time");
  AST_ST_CODE: assert property (lnk.done |-> lnk.code >= 8'h01 && lnk.code <= 8'h05) // see RL4
    else $error("self-test code out of range");
endmodule
`default_nettype wire
